//--- design/csp_serial_port.sv
// Codec serial frame port: AHB-Lite registers, bit clock and frame sync
// master or slave, 16-bit slots with daisy-chain slot handover.
// Assumes all pins are asynchronous to hclk; early frame sync, one bit
// before the first slot, the same timing as the slot chain handover.
// Operation
// - master pin high drives bit clock, else input
// - master bit clock 12.288 or 11.2896 MHz
// - master bit clock runs without any gaps
// - master pin high drives frame sync, else input
// - frame rate bit 0: half rate, two samples
// - frame rate bit 1: full rate, one sample
// - ready after 171 ms, 6 ms after change
// - readback words out MSB first, three-state idle
// - chain input takes three or six slots
// - chain output high with last slot LSB
`timescale 1ns/1ns
module csp_serial_port #(
  parameter int INIT_CYCLES = csp_pkg::INIT_CYC,
  parameter int CHANGE_CYCLES = csp_pkg::CHANGE_CYC,
  parameter int FRAME_BITS = csp_pkg::FRAME_BITS,
  parameter int DEPTH = csp_pkg::TX_DEPTH
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial bus pins
  input wire logic master_select_pin,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  input wire logic frame_sync_line_in,
  output logic frame_sync_line_out,
  output logic frame_sync_line_oe,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_oe,
  input wire logic slot_chain_in,
  output logic slot_chain_out
);
  localparam int FW = $clog2(FRAME_BITS);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [FW-1:0] LAST_FULL = FW'(FRAME_BITS - 1);
  localparam logic [FW-1:0] LAST_HALF = FW'(FRAME_BITS / 2 - 1);
  localparam logic [3:0] LAST_BIT = 4'(csp_pkg::WORD_BITS - 1);

  csp_pkg::csp_pins_t sync1, s;
  csp_pkg::csp_ctrl_t ctrl;
  csp_pkg::csp_state_t state;
  logic bclk_d, bclk_q, fs_q, start_seen, chain_q, rx_valid, rx_ovr;
  logic [31:0] acc;
  logic [FW-1:0] bit_cnt;
  logic [2:0] slot;
  logic [3:0] bitn;
  logic [15:0] tx_sh, rx_sh, rx_word;
  logic [24:0] wait_cnt;
  logic dph_wr;
  logic [3:0] dph_addr;
  logic [15:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] count;

  // Every pin passes two flops; only s is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      s <= '0;
    end else begin
      sync1 <= {master_select_pin, bit_clock_in, frame_sync_line_in, serial_in_line,
                slot_chain_in};
      s <= sync1;
    end
  end

  wire master = s.msel;
  wire [31:0] inc = ctrl.crystal_b ? csp_pkg::NCO_INC_B : csp_pkg::NCO_INC_A;
  wire [32:0] next_acc = {1'b0, acc} + {1'b0, inc};
  wire tgl = next_acc[32];
  wire bclk_rise = master ? (tgl & ~bclk_q) : (s.bclk & ~bclk_d);
  wire bclk_fall = master ? (tgl & bclk_q) : (~s.bclk & bclk_d);
  wire [FW-1:0] frame_last = ctrl.frame_rate_select ? LAST_HALF : LAST_FULL;
  wire [FW-1:0] next_bit_cnt = (bit_cnt == frame_last) ? '0 : bit_cnt + 1'b1;
  wire [2:0] last_slot = (ctrl.slot_count_select ? csp_pkg::SLOTS_NARROW
                         : csp_pkg::SLOTS_WIDE) - 3'h1;
  wire ready = (wait_cnt == '0);
  wire active = (state == csp_pkg::CSP_ACTIVE);
  wire word_end = active & (bitn == LAST_BIT);
  wire load = (~active & start_seen & ready) | (word_end & (slot != last_slot));
  wire empty = (count == '0);
  wire full = (count == CW'(DEPTH));
  wire pop = bclk_rise & load & ~empty;
  wire [15:0] tx_word = empty ? 16'h0000 : mem[rd_ptr];

  // Bit clock: phase accumulator keeps the average rate exact, free running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= '0;
      bclk_q <= 1'b0;
      bclk_d <= 1'b0;
    end else begin
      acc <= next_acc[31:0];
      bclk_q <= bclk_q ^ tgl;
      bclk_d <= s.bclk;
    end
  end
  assign bit_clock_out = bclk_q;
  assign bit_clock_oe = master;

  // Master frame counter; sync goes high for the bit before the frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt <= '0;
      fs_q <= 1'b0;
    end else if (bclk_rise) begin
      bit_cnt <= next_bit_cnt;
      fs_q <= (next_bit_cnt == frame_last);
    end
  end
  assign frame_sync_line_out = fs_q;
  assign frame_sync_line_oe = master;

  // Falling edge: sample start request and receive data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_seen <= 1'b0;
      rx_sh <= '0;
    end else if (bclk_fall) begin
      start_seen <= (master ? fs_q : s.fs) | s.chain;
      if (active) begin
        rx_sh <= {rx_sh[14:0], s.din};
      end
    end
  end
  wire rx_done = bclk_fall & word_end;

  // Rising edge: slot sequencer and transmit shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= csp_pkg::CSP_IDLE;
      slot <= '0;
      bitn <= '0;
      tx_sh <= '0;
      chain_q <= 1'b0;
    end else if (bclk_rise) begin
      chain_q <= active & (bitn == LAST_BIT - 4'h1) & (slot == last_slot);
      case (state)
        csp_pkg::CSP_IDLE: begin
          if (load) begin
            state <= csp_pkg::CSP_ACTIVE;
            slot <= '0;
            bitn <= '0;
            tx_sh <= tx_word;
          end
        end
        csp_pkg::CSP_ACTIVE: begin
          if (word_end && slot == last_slot) begin
            state <= csp_pkg::CSP_IDLE;
          end else if (word_end) begin
            slot <= slot + 3'h1;
            bitn <= '0;
            tx_sh <= tx_word;
          end else begin
            bitn <= bitn + 4'h1;
            tx_sh <= {tx_sh[14:0], 1'b0};
          end
        end
        default: state <= csp_pkg::CSP_IDLE;
      endcase
    end
  end
  assign serial_out_line = tx_sh[15];
  assign serial_out_oe = active;
  assign slot_chain_out = chain_q;

  // AHB-Lite decode; only TXDATA writes to a full buffer wait
  wire acc_ok = hsel & htrans[1] & hready;
  wire in_map = (haddr[31:4] == 28'h0) & (haddr[1:0] == 2'h0);
  wire rd_rx = acc_ok & ~hwrite & in_map & (haddr[3:0] == csp_pkg::ADDR_RXDATA);
  wire stall = dph_wr & (dph_addr == csp_pkg::ADDR_TXDATA) & full;
  wire wr_go = dph_wr & ~stall;
  wire push = wr_go & (dph_addr == csp_pkg::ADDR_TXDATA);
  wire wr_ctrl = wr_go & (dph_addr == csp_pkg::ADDR_CTRL);
  wire ovr_clr = wr_go & (dph_addr == csp_pkg::ADDR_STATUS) & hwdata[csp_pkg::STATUS_OVR_BIT];
  wire csp_pkg::csp_ctrl_t new_ctrl = hwdata[2:0];
  wire rate_change = wr_ctrl & ((new_ctrl.crystal_b != ctrl.crystal_b) |
                     (new_ctrl.frame_rate_select != ctrl.frame_rate_select));
  wire csp_pkg::csp_status_t status = {master, empty, full, rx_ovr, rx_valid, ready};
  wire [31:0] rd_mux = (haddr[3:0] == csp_pkg::ADDR_CTRL) ? {29'h0, ctrl} :
                       (haddr[3:0] == csp_pkg::ADDR_STATUS) ? {26'h0, status} :
                       (haddr[3:0] == csp_pkg::ADDR_RXDATA) ? {16'h0, rx_word} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr <= 1'b0;
      dph_addr <= '0;
      hrdata <= '0;
    end else if (hready) begin
      dph_wr <= acc_ok & hwrite & in_map;
      dph_addr <= haddr[3:0];
      hrdata <= (acc_ok & ~hwrite & in_map) ? rd_mux : 32'h0;
    end
  end
  assign hreadyout = ~stall;
  assign hresp = 1'b0;

  // Control, settle timer and receive flags; hardware set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= csp_pkg::CTRL_RESET;
      wait_cnt <= 25'(INIT_CYCLES);
      rx_word <= '0;
      rx_valid <= 1'b0;
      rx_ovr <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= new_ctrl;
      end
      if (rate_change) begin
        wait_cnt <= 25'(CHANGE_CYCLES);
      end else if (!ready) begin
        wait_cnt <= wait_cnt - 25'h1;
      end
      if (rx_done) begin
        rx_word <= {rx_sh[14:0], s.din};
      end
      rx_valid <= rx_done | (rx_valid & ~rd_rx);
      rx_ovr <= (rx_done & rx_valid & ~rd_rx) | (rx_ovr & ~ovr_clr);
    end
  end

  // Transmit buffer; DEPTH must be a power of two so pointers wrap freely
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr] <= hwdata[15:0];
    end
  end

  property p_bclk_dir;
    @(posedge hclk) disable iff (!hresetn) bit_clock_oe == s.msel;
  endproperty
  a_bclk_dir: assert property (p_bclk_dir) else $error("bit clock drive wrong");
  property p_bclk_runs;
    @(posedge hclk) disable iff (!hresetn) master |-> ##[0:5] tgl;
  endproperty
  a_bclk_runs: assert property (p_bclk_runs) else $error("bit clock stopped");
  property p_bclk_rate;
    @(posedge hclk) disable iff (!hresetn) tgl |=> !tgl ##1 !tgl;
  endproperty
  a_bclk_rate: assert property (p_bclk_rate) else $error("bit clock too fast");
  property p_fs_dir;
    @(posedge hclk) disable iff (!hresetn) frame_sync_line_oe == master && !(fs_q && chain_q);
  endproperty
  a_fs_dir: assert property (p_fs_dir) else $error("frame sync drive wrong");
  property p_fs_pos;
    @(posedge hclk) disable iff (!hresetn) $rose(fs_q) |-> bit_cnt == frame_last;
  endproperty
  a_fs_pos: assert property (p_fs_pos) else $error("frame length wrong");
  property p_out_idle;
    @(posedge hclk) disable iff (!hresetn) $rose(serial_out_oe) |-> $past(ready && start_seen);
  endproperty
  a_out_idle: assert property (p_out_idle) else $error("output driven unasked");
  property p_tso_lsb;
    @(posedge hclk) disable iff (!hresetn)
      $rose(slot_chain_out) |-> bitn == LAST_BIT && slot == last_slot;
  endproperty
  a_tso_lsb: assert property (p_tso_lsb) else $error("chain out misplaced");
  property p_release;
    @(posedge hclk) disable iff (!hresetn) (slot_chain_out && bclk_rise) |=> !serial_out_oe;
  endproperty
  a_release: assert property (p_release) else $error("slots not released");
  property p_busy;
    @(posedge hclk) disable iff (!hresetn) !ready && !active |=> !active;
  endproperty
  a_busy: assert property (p_busy) else $error("started while settling");
  property p_rx_word;
    @(posedge hclk) disable iff (!hresetn) $rose(rx_valid) |-> $past(bitn) == LAST_BIT;
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("word end wrong");
endmodule : csp_serial_port

//--- design/csp_pkg.sv
// Constants and types for the codec serial frame port.
// Assumes a 100 MHz hclk and an AHB-Lite master with 32-bit data.
package csp_pkg;
  localparam longint CLK_HZ = 100_000_000;
  localparam longint BCLK_A_HZ = 12_288_000;
  localparam longint BCLK_B_HZ = 11_289_600;
  // Phase step per hclk for a bit clock that toggles at twice its rate
  localparam logic [31:0] NCO_INC_A = 32'((BCLK_A_HZ * 2 * (64'd1 << 32)) / CLK_HZ);
  localparam logic [31:0] NCO_INC_B = 32'((BCLK_B_HZ * 2 * (64'd1 << 32)) / CLK_HZ);
  localparam int WORD_BITS = 16;
  localparam int FRAME_BITS = 256;
  localparam logic [2:0] SLOTS_WIDE = 3'h6;
  localparam logic [2:0] SLOTS_NARROW = 3'h3;
  localparam longint INIT_TIME_MS = 171;
  localparam longint CHANGE_TIME_MS = 6;
  localparam int INIT_CYC = int'(INIT_TIME_MS * (CLK_HZ / 1000));
  localparam int CHANGE_CYC = int'(CHANGE_TIME_MS * (CLK_HZ / 1000));
  localparam int TX_DEPTH = 2;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_TXDATA = 4'h8;
  localparam logic [3:0] ADDR_RXDATA = 4'hC;
  localparam int STATUS_OVR_BIT = 2;
  typedef struct packed {
    logic crystal_b;
    logic slot_count_select;
    logic frame_rate_select;
  } csp_ctrl_t;
  localparam csp_ctrl_t CTRL_RESET = 3'h0;
  typedef struct packed {
    logic master;
    logic tx_empty;
    logic tx_full;
    logic rx_overrun;
    logic rx_valid;
    logic ready;
  } csp_status_t;
  typedef struct packed {
    logic msel;
    logic bclk;
    logic fs;
    logic din;
    logic chain;
  } csp_pins_t;
  typedef enum logic [0:0] {
    CSP_IDLE = 1'b0,
    CSP_ACTIVE = 1'b1
  } csp_state_t;
endpackage : csp_pkg

//--- dv/csp_host_model.sv
// Host serial port model: bit clock and frame sync while the codec is a slave,
// 16-bit words on the input line, and capture of every word the codec returns.
// Assumes the bench resolves the shared lines from the codec's enables.
`timescale 1ns/1ns
module csp_host_model (
  // Mode pin
  input wire logic master_select_pin,
  // Resolved serial lines
  input wire logic bclk,
  input wire logic fs,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  input wire logic slot_chain_out,
  // Host drive
  output logic host_bclk,
  output logic host_fs,
  output logic serial_in_line
);
  logic [7:0] cnt = 8'h00;
  logic fs_seen = 1'b0;
  logic [15:0] w = 16'h0000;
  logic [15:0] sr = 16'h0000;
  int bits = 0;
  int tso_at = -1;
  logic [15:0] got[$];
  initial host_bclk = 1'b0;
  initial host_fs = 1'b0;
  initial serial_in_line = 1'b0;
  // Clock stands only while the codec is master, so the bus never has two
  always begin
    #63 host_bclk = master_select_pin ? 1'b0 : ~host_bclk;
    #62 host_bclk = master_select_pin ? 1'b0 : ~host_bclk;
  end
  // Sync marks the bit before slot 0; outside slots the line keeps toggling
  always @(posedge bclk) begin
    cnt = fs_seen ? 8'h00 : cnt + 8'h01;
    w = {12'h9C3, 1'b0, cnt[6:4]};
    host_fs <= (cnt == 8'hFF);
    serial_in_line <= (cnt < 8'd96) ? w[4'hF - cnt[3:0]] : cnt[0];
  end
  always @(negedge bclk) begin
    fs_seen <= fs;
    if (serial_out_oe === 1'b1) begin
      sr = {sr[14:0], serial_out_line};
      bits = bits + 1;
      if (slot_chain_out === 1'b1) tso_at = bits;
      if (bits % 16 == 0) got.push_back(sr);
    end
  end
endmodule : csp_host_model

//--- dv/csp_serial_port_tb.sv
// Self-checking bench for the codec serial frame port over AHB-Lite.
// Assumes csp_host_model on the serial side; short init and settle times.
`timescale 1ns/1ns
module csp_serial_port_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic msel = 1'b0;
  logic hreadyout, bco, bcoe, fso, fsoe, din_w, dout_w, sdoe, sco, hbclk, hfs;
  logic [31:0] hrdata;
  wire logic bclk_w = bcoe ? bco : hbclk;
  wire logic fs_w = fsoe ? fso : hfs;
  int error_cnt = 0;
  int checks_done = 0;
  always #5 hclk = ~hclk;
  csp_serial_port #(.INIT_CYCLES(50), .CHANGE_CYCLES(20)) i_csp_serial_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .master_select_pin(msel),
    .bit_clock_in(bclk_w), .bit_clock_out(bco), .bit_clock_oe(bcoe),
    .frame_sync_line_in(fs_w), .frame_sync_line_out(fso), .frame_sync_line_oe(fsoe),
    .serial_in_line(din_w), .serial_out_line(dout_w), .serial_out_oe(sdoe),
    .slot_chain_in(1'b0), .slot_chain_out(sco));
  csp_host_model i_csp_host_model (
    .master_select_pin(msel), .bclk(bclk_w), .fs(fs_w), .serial_out_line(dout_w),
    .serial_out_oe(sdoe), .slot_chain_out(sco), .host_bclk(hbclk), .host_fs(hfs),
    .serial_in_line(din_w));
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus_wait(input int lim, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < lim);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      $display("Error hready: expected 1, seen timeout");
      conclude();
    end
  endtask : bus_wait
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r, output int stall);
    int n;
    @(posedge hclk);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    bus_wait(10, n);
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait(60000, stall);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    int s;
    xfer(1'b1, a, d, r, s);
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    int s;
    xfer(1'b0, a, 32'h0, r, s);
  endtask : rd
  task automatic test_regs();
    logic [31:0] r;
    rd(32'h0, r);
    chk("ctrl reset", 32'h0, r);
    rd(32'h4, r);
    chk("ready in init", 32'h0, {31'h0, r[0]});
    rd(32'h20, r);
    chk("unmapped read", 32'h0, r);
    repeat (60) @(posedge hclk);
    rd(32'h4, r);
    chk("ready after init", 32'h1, {31'h0, r[0]});
    $display("test_regs done");
  endtask : test_regs
  task automatic test_slave();
    logic [31:0] r;
    int s;
    int n;
    chk("slave oe", 32'h0, {30'h0, bcoe, fsoe});
    wr(32'h0, 32'h2);
    wr(32'h8, 32'h5AF0);
    wr(32'h8, 32'h0F1E);
    // Third word must wait for the first slot to free an entry
    xfer(1'b1, 32'h8, 32'hC381, r, s);
    chk("tx stall", 32'h1, {31'h0, s > 100});
    for (n = 0; n < 20000 && i_csp_host_model.got.size() < 3; n++) @(posedge hclk);
    if (n >= 20000) begin
      error_cnt++;
      $display("Error host words: expected 3, seen timeout");
      conclude();
    end
    repeat (400) @(posedge hclk);
    chk("word 0", 32'h5AF0, 32'(i_csp_host_model.got[0]));
    chk("word 1", 32'h0F1E, 32'(i_csp_host_model.got[1]));
    chk("word 2", 32'hC381, 32'(i_csp_host_model.got[2]));
    chk("slot count", 32'd3, 32'(i_csp_host_model.got.size()));
    chk("chain out bit", 32'd48, 32'(i_csp_host_model.tso_at));
    chk("out oe idle", 32'h0, {31'h0, sdoe});
    rd(32'h4, r);
    chk("status rx", 32'h17, {26'h0, r[5:0]});
    rd(32'hC, r);
    chk("rx word", 32'h9C32, r);
    wr(32'h4, 32'h4);
    rd(32'h4, r);
    chk("status cleared", 32'h11, {26'h0, r[5:0]});
    $display("test_slave done");
  endtask : test_slave
  task automatic meas(output int rises, output int frame);
    logic pb;
    logic pf;
    int since;
    rises = 0;
    frame = 0;
    since = 0;
    pb = bco;
    pf = fso;
    repeat (10000) begin
      @(posedge hclk);
      if (bco === 1'b1 && pb === 1'b0) begin
        rises++;
        since++;
      end
      if (fso === 1'b1 && pf === 1'b0) begin
        frame = since;
        since = 0;
      end
      pb = bco;
      pf = fso;
    end
  endtask : meas
  task automatic test_master();
    logic [31:0] r;
    int ri;
    int fr;
    msel <= 1'b1;
    wr(32'h0, 32'h0);
    repeat (10) @(posedge hclk);
    chk("master oe", 32'h3, {30'h0, bcoe, fsoe});
    rd(32'h4, r);
    chk("master status", 32'h1, {31'h0, r[5]});
    meas(ri, fr);
    chk("rate a", 32'h1, {31'h0, ri >= 1228 && ri <= 1229});
    chk("frame half rate", 32'd256, 32'(fr));
    wr(32'h0, 32'h1);
    rd(32'h4, r);
    chk("settling", 32'h0, {31'h0, r[0]});
    repeat (40) @(posedge hclk);
    rd(32'h4, r);
    chk("settled", 32'h1, {31'h0, r[0]});
    meas(ri, fr);
    chk("frame full rate", 32'd128, 32'(fr));
    wr(32'h0, 32'h4);
    meas(ri, fr);
    chk("rate b", 32'h1, {31'h0, ri >= 1128 && ri <= 1129});
    $display("test_master done");
  endtask : test_master
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs();
    test_slave();
    test_master();
    conclude();
  end
endmodule : csp_serial_port_tb
